/* tws_consts.vh */
`ifndef TWS_CONSTS_VH
`define TWS_CONSTS_VH

// ****************************************
// Register offsets on the register port.
// ****************************************
`define TWS_A_DATA 4'h0
`define TWS_A_DIV 4'h1
`define TWS_A_MODE 4'h2
`define TWS_A_COMM 4'h3
`define TWS_A_STAT 4'h4
`define TWS_A_OVCLR 4'h5
`define TWS_A_START 4'h6
`define TWS_A_STOP 4'h7
`define TWS_A_ENSTAT 4'h8
`define TWS_A_SOE 4'h9
`define TWS_A_LEVEL 4'ha
`define TWS_A_PSEL 4'hb
`define TWS_A_GATE 4'hc

// ****************************************
// Field positions.
// ****************************************
`define TWS_B_INTSRC 0
`define TWS_B_CLKSEL 1
`define TWS_B_TXEN 0
`define TWS_B_RXEN 1
`define TWS_B_DAP 2
`define TWS_B_CKP 3
`define TWS_B_LSB 4
`define TWS_B_LEN8 5
`define TWS_B_OVF 0
`define TWS_B_BFF 1
`define TWS_B_TSF 2
`define TWS_B_DLEV 0
`define TWS_B_CLEV 1

// ****************************************
// Reset values.
// ****************************************
`define TWS_RST_DIV 7'h00
`define TWS_RST_MODE 2'h0
`define TWS_RST_COMM 6'h20
`define TWS_RST_LEVEL 2'h3
`define TWS_RST_PSEL 8'h00
`define TWS_RST_DATA 8'h00

// ****************************************
// Index of the last edge per word.
// ****************************************
`define TWS_LAST_EDGE8 4'hf
`define TWS_LAST_EDGE7 4'hd

`endif

/* tws_sync.v */
`timescale 1ns/1ps

module tws_sync (
    // Clock and reset.
    input wire core_clk,
    input wire nrst,
    // Level in and out.
    input wire din,
    output wire dout
);

    reg meta_ff;
    reg sync_ff;

    // Two flops bring the pin level into the clock domain.
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
        end else begin
            meta_ff <= din;
            sync_ff <= meta_ff;
        end
    end

    assign dout = sync_ff;

endmodule

/* tws_prescaler.v */
`timescale 1ns/1ps

module tws_prescaler (
    // Clock and reset.
    input wire core_clk,
    input wire nrst,
    // Control.
    input wire run,
    input wire [7:0] sel,
    // Prescaled enables, a in bit 0 and b in bit 1.
    output wire [1:0] tick
);

    reg [14:0] cnt_ff;
    reg [1:0] tick_ff;

    // Free running count that all taps divide down from.
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_ff <= 15'h0000;
        end else if (!run) begin
            cnt_ff <= 15'h0000;
        end else begin
            cnt_ff <= cnt_ff + 15'h0001;
        end
    end

    // Each tap pulses once every two to the power of its exponent.
    genvar i;
    generate
        for (i = 0; i < 2; i = i + 1) begin : g_tap
            wire [15:0] mask;
            assign mask = (16'h0001 << sel[4*i+3:4*i]) - 16'h0001;
            always @(posedge core_clk or negedge nrst) begin
                if (!nrst) begin
                    tick_ff[i] <= 1'b0;
                end else begin
                    tick_ff[i] <= run & ((cnt_ff & mask[14:0]) == mask[14:0]);
                end
            end
        end
    endgenerate

    assign tick = tick_ff;

endmodule

/* tws_master.v */
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "tws_consts.vh"

// What this block does
// - Transmit drives shift clock and serial out.
// - Receive drives clock, samples serial in.
// - Event at transfer end or buffer empty.
// - Divider field sets clock, fastest clk/2.
// - Data phase bit leads first bit.
// - Polarity bit swaps output and sample edges.
// - Only receive reports overrun.
// - Clock select picks prescaler tap.
// - Write while buffer full overwrites word.
// - Interrupt source may change mid-transfer.
// - Stop bit halts channel enable status.
// - Output disable hands data level to software.
// - Clock gate off resets whole unit.
// - Start bit enables the channel.
// - Data write begins a transfer.
// - Seven or eight bits, either order.
// - Stop bit self clears, status read only.
module tws_master (
    // Clock and reset.
    input wire core_clk,
    input wire nrst,
    // Register port.
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output wire [7:0] reg_rdata,
    // Shift clock pin.
    output wire shift_clock_pin_o,
    output wire shift_clock_pin_oe_n,
    // Serial data pins.
    output wire serial_out_pin_o,
    output wire serial_out_pin_oe_n,
    input wire serial_in_pin,
    // Channel event pulse.
    output wire channel_interrupt
);

    // ****************************************
    // Declarations.
    // ****************************************
    localparam ST_IDLE = 1'b0;
    localparam ST_RUN = 1'b1;

    reg peripheral_clock_gate_ff;
    reg [6:0] divider_ff;
    reg interrupt_source_bit_ff;
    reg clock_select_ff;
    reg tx_en_ff;
    reg rx_en_ff;
    reg data_phase_bit_ff;
    reg clock_polarity_bit_ff;
    reg lsb_first_ff;
    reg len8_ff;
    reg channel_enabled_status_ff;
    reg output_enable_bit_ff;
    reg data_level_bit_ff;
    reg clock_level_bit_ff;
    reg [7:0] prescaler_select_reg_ff;
    reg [7:0] tx_buf_ff;
    reg buffer_full_flag_ff;
    reg [7:0] rx_data_ff;
    reg rx_full_ff;
    reg overrun_flag_ff;
    reg state_ff;
    reg [6:0] hcnt_ff;
    reg [3:0] ecnt_ff;
    reg [7:0] sh_ff;
    reg so_ff;
    reg sck_ff;
    reg irq_ff;
    reg [7:0] rdata_ff;
    reg sck_pin_ff;
    reg sck_oe_n_ff;
    reg so_pin_ff;
    reg so_oe_n_ff;
    reg [7:0] nxt_rdata;

    wire sin_sync;
    wire [1:0] tick;
    wire op_tick;
    wire wr_data;
    wire rd_data;
    wire wr_div;
    wire wr_mode;
    wire wr_comm;
    wire wr_ovclr;
    wire wr_start;
    wire wr_stop;
    wire wr_soe;
    wire wr_level;
    wire wr_psel;
    wire start_ok;
    wire sample_edge;
    wire last_edge;
    wire half_done;
    wire idle_lvl;
    wire transfer_active_flag;
    wire [7:0] sh_in;
    wire [7:0] rx_word;

    // ****************************************
    // Helpers.
    // ****************************************

    // Picks the bit that goes out next from a shift word.
    function out_bit;
        input [7:0] w;
        input lsb;
        input len8;
        begin
            if (lsb) begin
                out_bit = w[0];
            end else if (len8) begin
                out_bit = w[7];
            end else begin
                out_bit = w[6];
            end
        end
    endfunction

    // ****************************************
    // Submodules.
    // ****************************************

    // Serial input comes from a pin, so it is synchronised.
    tws_sync u_sync (
        .core_clk(core_clk),
        .nrst(nrst),
        .din(serial_in_pin),
        .dout(sin_sync)
    );

    // Two prescaler taps, both stopped while the unit is gated.
    tws_prescaler u_presc (
        .core_clk(core_clk),
        .nrst(nrst),
        .run(peripheral_clock_gate_ff),
        .sel(prescaler_select_reg_ff),
        .tick(tick)
    );

    // ****************************************
    // Register decode.
    // ****************************************

    // Writes other than the gate are ignored while gated off.
    assign wr_data = reg_wr & peripheral_clock_gate_ff & (reg_addr == `TWS_A_DATA);
    assign rd_data = reg_rd & peripheral_clock_gate_ff & (reg_addr == `TWS_A_DATA);
    assign wr_div = reg_wr & peripheral_clock_gate_ff & (reg_addr == `TWS_A_DIV);
    assign wr_mode = reg_wr & peripheral_clock_gate_ff & (reg_addr == `TWS_A_MODE);
    assign wr_comm = reg_wr & peripheral_clock_gate_ff & (reg_addr == `TWS_A_COMM);
    assign wr_ovclr = reg_wr & peripheral_clock_gate_ff & (reg_addr == `TWS_A_OVCLR);
    assign wr_start = reg_wr & peripheral_clock_gate_ff & (reg_addr == `TWS_A_START);
    assign wr_stop = reg_wr & peripheral_clock_gate_ff & (reg_addr == `TWS_A_STOP);
    assign wr_soe = reg_wr & peripheral_clock_gate_ff & (reg_addr == `TWS_A_SOE);
    assign wr_level = reg_wr & peripheral_clock_gate_ff & (reg_addr == `TWS_A_LEVEL);
    assign wr_psel = reg_wr & peripheral_clock_gate_ff & (reg_addr == `TWS_A_PSEL);

    // ****************************************
    // Engine terms.
    // ****************************************

    // The channel clock is one of the two prescaler taps.
    assign op_tick = clock_select_ff ? tick[1] : tick[0];
    assign half_done = op_tick & (hcnt_ff == divider_ff);
    // Sample edges are odd edges without lead, even edges with it.
    assign sample_edge = ecnt_ff[0] ^ data_phase_bit_ff;
    assign last_edge = ecnt_ff == (len8_ff ? `TWS_LAST_EDGE8 : `TWS_LAST_EDGE7);
    // Rest level makes the first output edge falling when polarity is 0.
    assign idle_lvl = ~(clock_polarity_bit_ff ^ data_phase_bit_ff);
    assign start_ok = channel_enabled_status_ff & buffer_full_flag_ff;
    assign transfer_active_flag = (state_ff == ST_RUN) | start_ok;

    // Incoming bit enters the end opposite the outgoing one.
    assign sh_in = lsb_first_ff ?
        (len8_ff ? {sin_sync, sh_ff[7:1]} : {1'b0, sin_sync, sh_ff[6:1]}) :
        (len8_ff ? {sh_ff[6:0], sin_sync} : {1'b0, sh_ff[5:0], sin_sync});
    assign rx_word = sample_edge ? sh_in : sh_ff;

    // ****************************************
    // Unit clock gate.
    // ****************************************

    // The gate is always writable and resets the rest when low.
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            peripheral_clock_gate_ff <= 1'b0;
        end else if (reg_wr && (reg_addr == `TWS_A_GATE)) begin
            peripheral_clock_gate_ff <= reg_wdata[0];
        end
    end

    // ****************************************
    // Configuration registers.
    // ****************************************

    // Settings, channel enable and software pin levels.
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            divider_ff <= `TWS_RST_DIV;
            {clock_select_ff, interrupt_source_bit_ff} <= `TWS_RST_MODE;
            {len8_ff, lsb_first_ff, clock_polarity_bit_ff,
                data_phase_bit_ff, rx_en_ff, tx_en_ff} <= `TWS_RST_COMM;
            channel_enabled_status_ff <= 1'b0;
            output_enable_bit_ff <= 1'b0;
            {clock_level_bit_ff, data_level_bit_ff} <= `TWS_RST_LEVEL;
            prescaler_select_reg_ff <= `TWS_RST_PSEL;
        end else if (!peripheral_clock_gate_ff) begin
            divider_ff <= `TWS_RST_DIV;
            {clock_select_ff, interrupt_source_bit_ff} <= `TWS_RST_MODE;
            {len8_ff, lsb_first_ff, clock_polarity_bit_ff,
                data_phase_bit_ff, rx_en_ff, tx_en_ff} <= `TWS_RST_COMM;
            channel_enabled_status_ff <= 1'b0;
            output_enable_bit_ff <= 1'b0;
            {clock_level_bit_ff, data_level_bit_ff} <= `TWS_RST_LEVEL;
            prescaler_select_reg_ff <= `TWS_RST_PSEL;
        end else begin
            if (wr_div) begin
                divider_ff <= reg_wdata[7:1];
            end
            // The source bit stays writable during a transfer.
            if (wr_mode) begin
                interrupt_source_bit_ff <= reg_wdata[`TWS_B_INTSRC];
                clock_select_ff <= reg_wdata[`TWS_B_CLKSEL];
            end
            if (wr_comm) begin
                tx_en_ff <= reg_wdata[`TWS_B_TXEN];
                rx_en_ff <= reg_wdata[`TWS_B_RXEN];
                data_phase_bit_ff <= reg_wdata[`TWS_B_DAP];
                clock_polarity_bit_ff <= reg_wdata[`TWS_B_CKP];
                lsb_first_ff <= reg_wdata[`TWS_B_LSB];
                len8_ff <= reg_wdata[`TWS_B_LEN8];
            end
            // Stop is a trigger; nothing of it is kept.
            if (wr_stop && reg_wdata[0]) begin
                channel_enabled_status_ff <= 1'b0;
            end else if (wr_start && reg_wdata[0]) begin
                channel_enabled_status_ff <= 1'b1;
            end
            if (wr_soe) begin
                output_enable_bit_ff <= reg_wdata[0];
            end
            if (wr_level) begin
                data_level_bit_ff <= reg_wdata[`TWS_B_DLEV];
                clock_level_bit_ff <= reg_wdata[`TWS_B_CLEV];
            end
            if (wr_psel) begin
                prescaler_select_reg_ff <= reg_wdata;
            end
        end
    end

    // ****************************************
    // Shift engine and data buffers.
    // ****************************************

    // One word per run; buffer, receive holding and flags live here.
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            tx_buf_ff <= `TWS_RST_DATA;
            buffer_full_flag_ff <= 1'b0;
            rx_data_ff <= `TWS_RST_DATA;
            rx_full_ff <= 1'b0;
            overrun_flag_ff <= 1'b0;
            state_ff <= ST_IDLE;
            hcnt_ff <= 7'h00;
            ecnt_ff <= 4'h0;
            sh_ff <= `TWS_RST_DATA;
            so_ff <= 1'b1;
            sck_ff <= 1'b1;
            irq_ff <= 1'b0;
        end else if (!peripheral_clock_gate_ff) begin
            tx_buf_ff <= `TWS_RST_DATA;
            buffer_full_flag_ff <= 1'b0;
            rx_data_ff <= `TWS_RST_DATA;
            rx_full_ff <= 1'b0;
            overrun_flag_ff <= 1'b0;
            state_ff <= ST_IDLE;
            hcnt_ff <= 7'h00;
            ecnt_ff <= 4'h0;
            sh_ff <= `TWS_RST_DATA;
            so_ff <= 1'b1;
            sck_ff <= 1'b1;
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= 1'b0;
            // A write while full simply replaces the pending word.
            if (wr_data) begin
                tx_buf_ff <= reg_wdata;
                buffer_full_flag_ff <= 1'b1;
            end
            if (rd_data) begin
                rx_full_ff <= 1'b0;
            end
            if (wr_ovclr && reg_wdata[`TWS_B_OVF]) begin
                overrun_flag_ff <= 1'b0;
            end
            case (state_ff)
                ST_IDLE: begin
                    sck_ff <= idle_lvl;
                    hcnt_ff <= 7'h00;
                    ecnt_ff <= 4'h0;
                    if (start_ok) begin
                        state_ff <= ST_RUN;
                        sh_ff <= tx_buf_ff;
                        // A write in this same cycle keeps the buffer full.
                        if (!wr_data) begin
                            buffer_full_flag_ff <= 1'b0;
                        end
                        if (interrupt_source_bit_ff) begin
                            irq_ff <= 1'b1;
                        end
                        if (data_phase_bit_ff) begin
                            so_ff <= out_bit(tx_buf_ff, lsb_first_ff, len8_ff);
                        end
                    end
                end
                ST_RUN: begin
                    if (!channel_enabled_status_ff) begin
                        state_ff <= ST_IDLE;
                    end else if (half_done) begin
                        hcnt_ff <= 7'h00;
                        sck_ff <= ~sck_ff;
                        ecnt_ff <= ecnt_ff + 4'h1;
                        if (sample_edge) begin
                            sh_ff <= sh_in;
                        end else begin
                            so_ff <= out_bit(sh_ff, lsb_first_ff, len8_ff);
                        end
                        if (last_edge) begin
                            state_ff <= ST_IDLE;
                            if (!interrupt_source_bit_ff) begin
                                irq_ff <= 1'b1;
                            end
                            if (rx_en_ff) begin
                                rx_data_ff <= rx_word;
                                // Set wins over a read in the same cycle.
                                rx_full_ff <= 1'b1;
                                if (rx_full_ff && !rd_data) begin
                                    overrun_flag_ff <= 1'b1;
                                end
                            end
                        end
                    end else if (op_tick) begin
                        hcnt_ff <= hcnt_ff + 7'h01;
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // Pin stage.
    // ****************************************

    // Stopped channel shows both software levels; disabled output shows only the data level.
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sck_pin_ff <= 1'b1;
            sck_oe_n_ff <= 1'b1;
            so_pin_ff <= 1'b1;
            so_oe_n_ff <= 1'b1;
        end else begin
            sck_pin_ff <= channel_enabled_status_ff ? sck_ff : clock_level_bit_ff;
            sck_oe_n_ff <= ~peripheral_clock_gate_ff;
            so_pin_ff <= (output_enable_bit_ff && channel_enabled_status_ff) ?
                so_ff : data_level_bit_ff;
            // The data output is left undriven when not transmitting.
            so_oe_n_ff <= ~(peripheral_clock_gate_ff & tx_en_ff);
        end
    end

    // ****************************************
    // Read port.
    // ****************************************

    // Read data selection; unmapped offsets read zero.
    always @* begin
        nxt_rdata = 8'h00;
        case (reg_addr)
            `TWS_A_DATA: nxt_rdata = rx_en_ff ? rx_data_ff : tx_buf_ff;
            `TWS_A_DIV: nxt_rdata = {divider_ff, 1'b0};
            `TWS_A_MODE: nxt_rdata = {6'h00, clock_select_ff, interrupt_source_bit_ff};
            `TWS_A_COMM: nxt_rdata = {2'h0, len8_ff, lsb_first_ff, clock_polarity_bit_ff,
                data_phase_bit_ff, rx_en_ff, tx_en_ff};
            `TWS_A_STAT: nxt_rdata = {5'h00, transfer_active_flag,
                buffer_full_flag_ff, overrun_flag_ff};
            `TWS_A_ENSTAT: nxt_rdata = {7'h00, channel_enabled_status_ff};
            `TWS_A_SOE: nxt_rdata = {7'h00, output_enable_bit_ff};
            `TWS_A_LEVEL: nxt_rdata = {6'h00, clock_level_bit_ff, data_level_bit_ff};
            `TWS_A_PSEL: nxt_rdata = prescaler_select_reg_ff;
            `TWS_A_GATE: nxt_rdata = {7'h00, peripheral_clock_gate_ff};
            default: nxt_rdata = 8'h00;
        endcase
    end

    // Read data stand only in the cycle after the strobe.
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_ff <= 8'h00;
        end else if (reg_rd) begin
            rdata_ff <= nxt_rdata;
        end else begin
            rdata_ff <= 8'h00;
        end
    end

    // ****************************************
    // Outputs.
    // ****************************************
    assign reg_rdata = rdata_ff;
    assign shift_clock_pin_o = sck_pin_ff;
    assign shift_clock_pin_oe_n = sck_oe_n_ff;
    assign serial_out_pin_o = so_pin_ff;
    assign serial_out_pin_oe_n = so_oe_n_ff;
    assign channel_interrupt = irq_ff;

endmodule

/* tws_properties.sv */
`timescale 1ns/1ps
`include "tws_consts.vh"

// ****************
// Port checker.
// ****************
module tws_properties (
    // Clock and reset.
    input logic core_clk,
    input logic nrst,
    // Register port.
    input logic [3:0] reg_addr,
    input logic [7:0] reg_wdata,
    input logic reg_wr,
    input logic reg_rd,
    input logic [7:0] reg_rdata,
    // Pins and event.
    input logic shift_clock_pin_o,
    input logic shift_clock_pin_oe_n,
    input logic serial_out_pin_o,
    input logic serial_out_pin_oe_n,
    input logic serial_in_pin,
    input logic channel_interrupt
);
    logic pol_ff, txen_ff;
    wire comm_wr = reg_wr && reg_addr == `TWS_A_COMM;
    wire gate_off = reg_wr && reg_addr == `TWS_A_GATE && !reg_wdata[0];
    wire stop_wr = reg_wr && reg_addr == `TWS_A_STOP && reg_wdata[0];
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // Mirrors polarity and transmit enable.
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pol_ff <= 1'b0;
            txen_ff <= 1'b0;
        end else begin
            pol_ff <= gate_off ? 1'b0 : comm_wr ? reg_wdata[`TWS_B_CKP] : pol_ff;
            txen_ff <= gate_off ? 1'b0 : comm_wr ? reg_wdata[`TWS_B_TXEN] : txen_ff;
        end
    end
    chk_clk_drive: assert property (
        $changed(shift_clock_pin_o) && !$past(gate_off, 3) |-> !shift_clock_pin_oe_n)
        else $error("clock moved while undriven");
    chk_irq_pulse: assert property (channel_interrupt |=> !channel_interrupt)
        else $error("event longer than one cycle");
    chk_half_min: assert property (
        $rose(shift_clock_pin_o) && !reg_wr |=> $stable(shift_clock_pin_o))
        else $error("clock half period below two cycles");
    chk_sample_stable: assert property (
        (pol_ff ? $fell(shift_clock_pin_o) : $rose(shift_clock_pin_o)) && !$past(reg_wr, 2)
        && !shift_clock_pin_oe_n |-> $stable(serial_out_pin_o))
        else $error("data moved on the sampling edge");
    chk_rx_only_oe: assert property (!$past(txen_ff) |-> serial_out_pin_oe_n)
        else $error("data pin driven without transmit");
    chk_gate_on: assert property (
        reg_wr && reg_addr == `TWS_A_GATE && reg_wdata[0] |-> ##[1:3] !shift_clock_pin_oe_n)
        else $error("clock not driven after gate on");
    chk_gate_off: assert property (
        gate_off |-> ##[1:3] (shift_clock_pin_oe_n && serial_out_pin_oe_n))
        else $error("pins driven after gate off");
    chk_stop_quiet: assert property (stop_wr |-> ##3 $stable(shift_clock_pin_o)[*4])
        else $error("clock running after stop");
    cover property (channel_interrupt);
    cover property ($rose(shift_clock_pin_o) && pol_ff);
    cover property (stop_wr);
endmodule

bind tws_master tws_properties u_props (.core_clk(core_clk), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .shift_clock_pin_o(shift_clock_pin_o),
    .shift_clock_pin_oe_n(shift_clock_pin_oe_n), .serial_out_pin_o(serial_out_pin_o),
    .serial_out_pin_oe_n(serial_out_pin_oe_n), .serial_in_pin(serial_in_pin),
    .channel_interrupt(channel_interrupt));

/* tws_slave_model.sv */
`timescale 1ns/1ps

// ****************
// Far-side slave.
// ****************
module tws_slave_model (
    // Serial lines.
    input wire sck,
    input wire sdo,
    output wire sdi,
    // Bench control.
    input wire pol,
    input wire load,
    input wire [7:0] word,
    output reg [7:0] rx
);
    integer ns = 0, nd = 0;
    // A new frame starts counting from zero.
    always @(posedge load) begin
        ns = 0;
        nd = 0;
    end
    // Samples on one edge, shifts on the other.
    always @(sck) begin
        if (sck ^ pol) begin
            rx = {rx[6:0], sdo};
            ns = ns + 1;
        end else if (ns > nd) begin
            nd = nd + 1;
        end
    end
    // Past the last sample the line flips.
    assign sdi = (ns > 7) ? ~word[(7 - nd) & 7] : word[(7 - nd) & 7];
endmodule

/* three_wire_serial_master_tb_top.sv */
`timescale 1ns/1ps
`include "tws_consts.vh"

// ****************
// Self-checking bench.
// ****************
module three_wire_serial_master_tb_top;
    reg core_clk = 1'b0;
    reg nrst = 1'b0;
    reg [3:0] reg_addr = 4'h0;
    reg [7:0] reg_wdata = 8'h00;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    reg load = 1'b0;
    reg pol = 1'b0;
    reg [7:0] sw = 8'h00;
    wire [7:0] reg_rdata;
    wire [7:0] slv_rx;
    wire sck, sck_oe_n, sdo, sdo_oe_n, sdi, irq;
    integer error_cnt = 0;
    integer samples_checked = 0;
    integer irq_n = 0;
    integer seed = 32'h6e542617;
    integer i, k, n0;
    reg [7:0] v;
    reg [7:0] exp_q[$];

    tws_master u_dut (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .shift_clock_pin_o(sck), .shift_clock_pin_oe_n(sck_oe_n), .serial_out_pin_o(sdo),
        .serial_out_pin_oe_n(sdo_oe_n), .serial_in_pin(sdi), .channel_interrupt(irq));
    tws_slave_model u_slave (.sck(sck), .sdo(sdo | sdo_oe_n), .sdi(sdi), .pol(pol), .load(load),
        .word(sw), .rx(slv_rx));

    // Clock and event counter.
    initial forever #5 core_clk = ~core_clk;
    always @(posedge core_clk) if (irq === 1'b1) irq_n <= irq_n + 1;

    task wr(input [3:0] a, input [7:0] d);
        begin
            @(posedge core_clk);
            reg_addr <= a;
            reg_wdata <= d;
            reg_wr <= 1'b1;
            @(posedge core_clk);
            reg_wr <= 1'b0;
        end
    endtask
    task rd(input [3:0] a, output [7:0] d);
        begin
            @(posedge core_clk);
            reg_addr <= a;
            reg_rd <= 1'b1;
            @(posedge core_clk);
            reg_rd <= 1'b0;
            #1 d = reg_rdata;
        end
    endtask
    task chk(input string n, input [31:0] e, input [31:0] s);
        begin
            samples_checked = samples_checked + 1;
            if (s !== e) begin
                error_cnt = error_cnt + 1;
                $display("[FAIL] %0s exp %0h got %0h", n, e, s);
            end
        end
    endtask
    task chk_rd(input [3:0] a, input [7:0] e);
        begin
            rd(a, v);
            chk("register", e, v);
        end
    endtask
    // Polls status until buffer and shifter are empty.
    task wait_idle;
        begin
            k = 0;
            v = 8'h06;
            while (v[2:1] !== 2'b00 && k < 300) begin
                rd(`TWS_A_STAT, v);
                k = k + 1;
            end
            chk("idle wait", 0, k >= 300);
        end
    endtask
    task complete_run;
        begin
            $display("checks %0d mismatches %0d", samples_checked, error_cnt);
            if (error_cnt == 0 && samples_checked > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask

    // Watchdog against a hang.
    initial begin
        #600000;
        error_cnt = error_cnt + 1;
        $display("[FAIL] watchdog exp done got hang");
        complete_run;
    end

    // Main sequence.
    initial begin
        repeat (6) @(posedge core_clk);
        nrst <= 1'b1;
        chk_rd(`TWS_A_COMM, 8'h20);
        chk_rd(`TWS_A_LEVEL, 8'h03);
        chk_rd(`TWS_A_ENSTAT, 8'h00);
        wr(`TWS_A_GATE, 8'h01);
        wr(4'hf, 8'hff);
        chk_rd(4'hf, 8'h00);
        wr(`TWS_A_DIV, 8'h06);
        wr(`TWS_A_PSEL, 8'h10);
        wr(`TWS_A_SOE, 8'h01);
        wr(`TWS_A_START, 8'h01);
        chk_rd(`TWS_A_ENSTAT, 8'h01);
        $display("test setup done");
        for (i = 0; i < 4; i = i + 1) begin
            pol = i[0];
            wr(`TWS_A_COMM, {2'b00, 2'b10, i[0], i[1], 1'b1, i != 2});
            wr(`TWS_A_MODE, {6'h00, i[0], 1'b0});
            sw = $random(seed);
            #1 load = 1'b1;
            #1 load = 1'b0;
            v = $random(seed);
            exp_q.push_back(i == 2 ? 8'hff : v);
            n0 = irq_n;
            wr(`TWS_A_DATA, v);
            wait_idle;
            chk("slave word", exp_q.pop_front(), slv_rx);
            chk("events", 1, irq_n - n0);
            chk_rd(`TWS_A_DATA, sw);
            chk_rd(`TWS_A_STAT, 8'h00);
        end
        $display("test modes done");
        wr(`TWS_A_DATA, $random(seed));
        wait_idle;
        wr(`TWS_A_DATA, $random(seed));
        wait_idle;
        chk_rd(`TWS_A_STAT, 8'h01);
        wr(`TWS_A_OVCLR, 8'h01);
        rd(`TWS_A_DATA, v);
        chk_rd(`TWS_A_STAT, 8'h00);
        $display("test overrun done");
        wr(`TWS_A_MODE, 8'h01);
        n0 = irq_n;
        wr(`TWS_A_DATA, $random(seed));
        wr(`TWS_A_DATA, $random(seed));
        sw = $random(seed);
        wr(`TWS_A_DATA, sw);
        #700;
        wr(`TWS_A_MODE, 8'h00);
        wait_idle;
        chk("kept word", sw, slv_rx);
        chk("events", 3, irq_n - n0);
        wr(`TWS_A_OVCLR, 8'h01);
        rd(`TWS_A_DATA, v);
        $display("test continuous done");
        wr(`TWS_A_DATA, $random(seed));
        repeat (10) @(posedge core_clk);
        wr(`TWS_A_STOP, 8'h01);
        chk_rd(`TWS_A_ENSTAT, 8'h00);
        chk_rd(`TWS_A_STOP, 8'h00);
        wr(`TWS_A_SOE, 8'h00);
        wr(`TWS_A_LEVEL, 8'h00);
        repeat (3) @(posedge core_clk);
        #1 chk("pin levels", 2'b00, {sck, sdo});
        $display("test stop done");
        wr(`TWS_A_GATE, 8'h00);
        chk_rd(`TWS_A_COMM, 8'h20);
        repeat (2) @(posedge core_clk);
        #1 chk("pin enables", 2'b11, {sck_oe_n, sdo_oe_n});
        $display("test gate done");
        complete_run;
    end
endmodule
